/* tb/aopc_props.sv */
// Port checker for the packet output controller
`timescale 1ns/1ps
`default_nettype none
module aopc_props
    import aopc_pkg::*;
(
    input wire logic              clk_sys,   // Clock
    input wire logic              rst,       // Reset
    input wire logic              psel,      // Select
    input wire logic              penable,   // Access
    input wire logic              pwrite,    // Write
    input wire logic [ADDR_W-1:0] paddr,     // Address
    input wire logic [31:0]       pwdata,    // Write data
    input wire logic              pready,    // Ready
    input wire logic [31:0]       prdata,    // Read data
    input wire logic              pslverr,   // Error
    input wire logic              srcReady,  // Accepts
    input wire logic              txByteClk, // Byte clock
    input wire logic [DATA_W-1:0] txData,    // Out byte
    input wire logic              txValid,   // Out valid
    input wire logic              txSync     // Sync strobe
);
    logic       enR;
    logic       clkQ;
    logic [3:0] riseAge;
    // Bus decode
    wire        ctrlWr = psel && penable && pwrite && (paddr == OFS_CTRL);
    wire        mapped = paddr inside {OFS_CTRL, OFS_STAT, OFS_BYTES};
    // Enable shadow and age of the last byte clock rise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enR     <= 1'b0;
            clkQ    <= 1'b0;
            riseAge <= 4'hF;
        end else begin
            enR     <= ctrlWr ? pwdata[CTRL_ENABLE] : enR;
            clkQ    <= txByteClk;
            riseAge <= (txByteClk && !clkQ) ? 4'h0 : riseAge + 4'(riseAge != 4'hF);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Register bus answers
    pready_high_a: assert property (pready) else $error("pready low");
    slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read data");
    // Output byte stream
    sync_byte_a: assert property (txSync |-> txValid && txData == SYNC_PATTERN)
        else $error("sync on wrong byte");
    valid_space_a: assert property (txValid |=> (!txValid) [*3])
        else $error("bytes too close");
    slot_cause_a: assert property (txValid |-> riseAge inside {[1:5]})
        else $error("byte without slot");
    // Source acceptance
    src_gate_a: assert property (!enR |-> !srcReady)
        else $error("ready while disabled");
    flush_stop_a: assert property (ctrlWr && pwdata[CTRL_FLUSH] |=> !srcReady)
        else $error("ready during flush");
    cover property (txSync);
    cover property (pslverr);
    cover property (ctrlWr && pwdata[CTRL_FLUSH]);
endmodule
bind aopc_output_ctrl aopc_props chk_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .srcReady, .txByteClk, .txData, .txValid, .txSync);
`default_nettype wire

/* tb/aopc_src_model.sv */
// Stream source model feeding bytes over the strobe and ready link
`timescale 1ns/1ps
`default_nettype none
module aopc_src_model
    import aopc_pkg::*;
(
    input  wire logic              clk_sys,  // Clock
    input  wire logic              srcReady, // Buffer accepts
    output logic                   srcValid, // Byte strobe
    output logic [DATA_W-1:0]      srcData,  // Stream byte
    output logic                   srcStart  // Packet start
);
    // Forces the start flag onto every byte, to test flag rejection
    logic startAll = 1'b0;
    // Idle link at time zero
    initial begin
        srcValid = 1'b0;
        srcData  = 8'h00;
        srcStart = 1'b0;
    end
    task automatic send(input logic [7:0] b, input int gap, input int lim, output logic ok);
        int n;
        ok = 1'b0;
        repeat (gap) @(posedge clk_sys);
        srcValid <= 1'b1;
        srcData  <= b;
        // flag on sync byte, or on any byte when forced
        srcStart <= (b == SYNC_PATTERN) | startAll;
        for (n = 0; n < lim && !ok; n++) begin
            @(posedge clk_sys);
            ok = srcReady;
        end
        srcValid <= 1'b0;
        srcData  <= ~b;
        srcStart <= (b != SYNC_PATTERN);
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the packet output controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failCount++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top
    import aopc_pkg::*;
;
    logic              clk_sys, rst, psel, penable, pwrite, pready, pslverr, slotRun;
    logic              srcValid, srcStart, srcReady, txValid, txSync;
    logic              txByteClk = 1'b0;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic [7:0]        srcData, txData;
    logic [1:0]        slotCnt = 2'h0;
    logic [8:0]        outQ[$];
    logic [7:0]        tbl[6] = '{8'h47, 8'h00, 8'hFF, 8'h47, 8'hA5, 8'h5A};
    logic [7:0]        pk[7] = '{8'h11, 8'h47, 8'h01, 8'h02, 8'h03, 8'h47, 8'h04};
    int                failCount = 0;
    int                compares = 0;

    aopc_output_ctrl dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .srcValid, .srcData, .srcStart, .srcReady, .txByteClk, .txData,
        .txValid, .txSync);
    aopc_src_model src_u (.clk_sys, .srcReady, .srcValid, .srcData, .srcStart);

    // System clock, 40 ns period
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Byte slot clock, six system clocks a period, low when stopped
    always @(posedge clk_sys) begin
        slotCnt <= (slotCnt == 2'h2) ? 2'h0 : slotCnt + 2'h1;
        if (slotCnt == 2'h2) txByteClk <= slotRun & ~txByteClk;
    end
    // Collect every qualified output byte with its sync strobe
    always @(posedge clk_sys) begin
        if (txValid === 1'b1) outQ.push_back({txSync, txData});
    end

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Ends the run when a bounded wait ran out
    task automatic limit(input logic hit);
        if (hit) begin
            failCount++;
            $display("[ERR] wait limit expected 0 seen 1");
            tally_and_finish;
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 9);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        limit(pready !== 1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        er;
        apb(1'b1, a, d, x, er);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, e);
        logic [31:0] d;
        logic        er;
        apb(1'b0, a, 32'h0, d, er);
        `CHK(nm, e & m, d & m)
    endtask
    task automatic waitq(input int n);
        for (int k = 0; k < 3000 && outQ.size() < n; k++) @(posedge clk_sys);
        limit(outQ.size() < n);
    endtask

    // Reset values, read-only and unmapped places
    task automatic reg_reset_t;
        logic [31:0] d;
        logic        er;
        rdchk("ctrl", OFS_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
        rdchk("stat", OFS_STAT, 32'h001F_03FF, 32'h0008_0000);
        wr(OFS_BYTES, 32'h0000_0055);
        rdchk("bytes ro", OFS_BYTES, 32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 12'h00C, 32'h0, d, er);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, d)
    endtask
    // Byte mode forwards each byte in order, no holding
    task automatic byte_mode_t;
        logic ok;
        outQ.delete();
        wr(OFS_CTRL, 32'h0000_0002);
        slotRun <= 1'b1;
        foreach (tbl[i]) src_u.send(tbl[i], 1, 20, ok);
        waitq(6);
        repeat (40) @(posedge clk_sys);
        `CHK("byte count", 6, outQ.size())
        foreach (tbl[i]) `CHK("byte", {tbl[i] == 8'h47, tbl[i]}, outQ[i])
        rdchk("sent", OFS_BYTES, 32'hFFFF_FFFF, 32'h6);
        // Start flag on a plain byte is dropped and raises the error bit
        src_u.startAll = 1'b1;
        src_u.send(8'h46, 1, 20, ok);
        src_u.startAll = 1'b0;
        waitq(7);
        `CHK("flag dropped", {1'b0, 8'h46}, outQ[6])
        rdchk("start err", OFS_STAT, 32'h0002_0000, 32'h0002_0000);
        wr(OFS_STAT, 32'h0002_0000);
        rdchk("err clear", OFS_STAT, 32'h0002_0000, 32'h0);
    endtask
    // Packet mode holds a packet until the next start is buffered
    task automatic packet_mode_t;
        logic ok;
        outQ.delete();
        wr(OFS_CTRL, 32'h0000_0007);
        rdchk("mode", OFS_CTRL, 32'hFFFF_FFFF, 32'h3);
        for (int i = 0; i < 5; i++) src_u.send(pk[i], 1, 20, ok);
        repeat (40) @(posedge clk_sys);
        `CHK("held", 0, outQ.size())
        rdchk("holding", OFS_STAT, 32'h0004_0000, 32'h0004_0000);
        src_u.send(pk[5], 1, 20, ok);
        src_u.send(pk[6], 1, 20, ok);
        waitq(4);
        repeat (40) @(posedge clk_sys);
        `CHK("pkt count", 4, outQ.size())
        for (int i = 0; i < 4; i++) `CHK("pkt", {i == 0, pk[i + 1]}, outQ[i])
        rdchk("hold again", OFS_STAT, 32'h0004_0000, 32'h0004_0000);
        rdchk("sent", OFS_BYTES, 32'hFFFF_FFFF, 32'h4);
    endtask
    // Fill until refused, overflow flag, drain order, reset empties
    task automatic full_t;
        logic ok;
        int   n;
        n = 0;
        slotRun <= 1'b0;
        repeat (12) @(posedge clk_sys);
        wr(OFS_CTRL, 32'h0000_0006);
        outQ.delete();
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            src_u.send(8'(i), 1, 4, ok);
            n += int'(ok);
        end
        `CHK("accepted", FIFO_DEPTH, n)
        src_u.send(8'h99, 1, 4, ok);
        `CHK("refused", 1'b0, ok)
        rdchk("full", OFS_STAT, 32'h0011_03FF, 32'h0011_0200);
        wr(OFS_STAT, 32'h0001_0000);
        rdchk("ovf clear", OFS_STAT, 32'h0001_0000, 32'h0);
        slotRun <= 1'b1;
        waitq(4);
        for (int i = 0; i < 4; i++) `CHK("drain", {1'b0, 8'(i)}, outQ[i])
        slotRun <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdchk("after reset", OFS_STAT, 32'h001F_03FF, 32'h0008_0000);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, slotRun} = 4'h0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        reg_reset_t;
        byte_mode_t;
        packet_mode_t;
        full_t;
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* verilog/aopc_fifo.sv */
// Show-ahead FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module aopc_fifo #(
    parameter int WIDTH   = 9,
    parameter int DEPTH   = 512,
    parameter int LEVEL_W = 10
) (
    input  wire logic               clk_sys,  // System clock
    input  wire logic               rst,      // Async reset, active high
    input  wire logic               clear,    // Empty the buffer
    input  wire logic               wrValid,  // Write request
    output logic                    wrReady,  // Space available
    input  wire logic [WIDTH-1:0]   wrData,   // Write word
    output logic                    rdValid,  // Head word present
    input  wire logic               rdReady,  // Pop head word
    output logic [WIDTH-1:0]        rdData,   // Head word
    output logic [LEVEL_W-1:0]      level     // Words held
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0]   wrPtr_r;
    logic [PTR_W:0]   rdPtr_r;
    wire              push;
    wire              pop;
    wire  [PTR_W:0]   fill;

    // Pointer difference gives fill level; extra bit separates full from empty
    assign fill    = wrPtr_r - rdPtr_r;
    assign level   = LEVEL_W'(fill);
    assign wrReady = (fill != (PTR_W+1)'(DEPTH));
    assign rdValid = (fill != '0);
    assign push    = wrValid & wrReady & ~clear;
    assign pop     = rdReady & rdValid & ~clear;
    assign rdData  = mem[rdPtr_r[PTR_W-1:0]];

    // Storage array, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_r[PTR_W-1:0]] <= wrData;
        end
    end

    // Pointers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else if (clear) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_r + (PTR_W+1)'(push);
            rdPtr_r <= rdPtr_r + (PTR_W+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* verilog/aopc_output_ctrl.sv */
// Packet output controller: stream buffer, packet release logic and APB registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Control bit selects byte-wise sparse mode or packet-by-packet mode.
// - Output only on transmitter byte slots, so never above 216 Mbps.
// - Each output byte carries a valid qualifier; empty slots show it low.
// - Byte mode forwards every received byte unchanged, no packet grouping.
// - Packet buffer is 9 bits wide and 512 entries deep.
// - Buffer word holds 8 data bits and one packet-start flag bit.
// - Start flag kept only on start bytes equal to 47h; others clear.
// - Read side halts at a packet-start flag while writes continue.
// - Write side signals the read side on each packet-start flag written.
// - Read side then sends bytes until the next packet-start flag.
// - Writes at source rate; reads paced by the 27 MHz byte clock.
// - Packet mode output is aligned to the packet sync strobe.
// - Byte mode uses the buffer only for rate crossing, no holding.
// - A 32-bit control register on the register bus steers the block.
// - Source link has 8 data lines plus control lines inbound, and one ready line back.
// - Output bytes go in parallel to the serialising line transmitter.
// - Byte mode must be chosen when packets are assembled elsewhere.
module aopc_output_ctrl
    import aopc_pkg::*;
(
    input  wire logic              clk_sys,    // System clock, 25 MHz
    input  wire logic              rst,        // Async reset, active high
    // APB slave
    input  wire logic              psel,       // APB select
    input  wire logic              penable,    // APB access phase
    input  wire logic              pwrite,     // APB write
    input  wire logic [ADDR_W-1:0] paddr,      // APB byte address
    input  wire logic [31:0]       pwdata,     // APB write data
    output logic                   pready,     // APB ready
    output logic [31:0]            prdata,     // APB read data
    output logic                   pslverr,    // APB error, unmapped
    // Stream source receive group
    // source byte lines
    input  wire logic              srcValid,   // Byte strobe from source
    input  wire logic [DATA_W-1:0] srcData,    // Stream byte
    input  wire logic              srcStart,   // Packet start flag
    output logic                   srcReady,   // Buffer accepts byte
    // Line transmitter side
    input  wire logic              txByteClk,  // Byte clock from transmitter
    output logic [DATA_W-1:0]      txData,     // Parallel byte out
    output logic                   txValid,    // Data valid qualifier
    output logic                   txSync      // Packet sync strobe
);
    aopc_rd_state_type   state_r;
    aopc_rd_state_type   state_nxt;
    logic [31:0]         ctrl_r;
    logic [31:0]         prdata_r;
    logic [31:0]         byteCount_r;
    logic [LEVEL_W-1:0]  syncCount_r;
    logic                sentAny_r;
    logic                ovf_r;
    logic                syncErr_r;
    logic                flush_r;
    logic [DATA_W-1:0]   txData_r;
    logic                txValid_r;
    logic                txSync_r;

    wire                 slot;
    wire                 fifoWrReady;
    wire                 fifoRdValid;
    wire  [FIFO_W-1:0]   fifoRdData;
    wire  [LEVEL_W-1:0]  fifoLevel;
    wire  [FIFO_W-1:0]   wrWord;
    wire                 wrSync;
    wire                 push;
    wire                 pop;
    wire                 emit;
    wire                 drop;
    wire                 headSync;
    wire                 pktMode;
    wire                 enabled;
    wire                 fifoFull;
    wire                 apbSetup;
    wire                 apbWrite;
    wire                 apbAccess;
    wire                 selCtrl;
    wire                 selStat;
    wire                 selBytes;
    wire                 mapped;
    wire  [31:0]         statWord;
    wire  [31:0]         readWord;
    wire                 ovfSet;
    wire                 ovfClr;
    wire                 errSet;
    wire                 errClr;

    // Byte slot pacing from the transmitter byte clock
    // read pacing
    aopc_slot_sync u_slot (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .slotIn    (txByteClk),
        .slotPulse (slot)
    );

    aopc_fifo #(
        .WIDTH   (FIFO_W),
        .DEPTH   (FIFO_DEPTH),
        .LEVEL_W (LEVEL_W)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (flush_r),
        .wrValid (push),
        .wrReady (fifoWrReady),
        .wrData  (wrWord),
        .rdValid (fifoRdValid),
        .rdReady (pop),
        .rdData  (fifoRdData),
        .level   (fifoLevel)
    );

    // Control fields
    // mode select
    assign pktMode  = ctrl_r[CTRL_PKT_MODE];
    assign enabled  = ctrl_r[CTRL_ENABLE];
    assign fifoFull = ~fifoWrReady;

    // Write side: flag only genuine 47h start bytes
    // start flag qualify
    assign wrSync   = srcStart & (srcData == SYNC_PATTERN);
    assign wrWord   = {wrSync, srcData};
    assign srcReady = enabled & fifoWrReady & ~flush_r;
    assign push     = srcValid & srcReady;

    // Read side decode
    assign headSync = fifoRdValid & fifoRdData[SYNC_BIT];
    assign emit = enabled & slot & fifoRdValid &
                  (~pktMode | ((state_r == RD_SEND) & ~(headSync & sentAny_r)));
    // Leading bytes before the first packet start are discarded
    assign drop = enabled & pktMode & (state_r == RD_SEEK) & fifoRdValid & ~headSync;
    assign pop  = emit | drop;

    // Packet release state machine
    always_comb begin
        state_nxt = state_r;
        if (!pktMode || !enabled) begin
            state_nxt = RD_SEEK;
        end else begin
            case (state_r)
                RD_SEEK: begin
                    if (headSync) begin
                        state_nxt = RD_HOLD;
                    end
                end
                RD_HOLD: begin
                    if ((syncCount_r >= SYNC_RELEASE) || fifoFull) begin
                        state_nxt = RD_SEND;
                    end
                end
                RD_SEND: begin
                    if (headSync && sentAny_r) begin
                        state_nxt = RD_HOLD;
                    end
                end
                default: begin
                    state_nxt = RD_SEEK;
                end
            endcase
        end
    end

    // State register and packet-tracking state
    // reset and flush clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= RD_SEEK;
        end else if (flush_r) begin
            state_r <= RD_SEEK;
        end else begin
            state_r <= state_nxt;
        end
    end

    // First byte of a released packet is its own start byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sentAny_r <= 1'b0;
        end else if (flush_r || state_nxt != RD_SEND) begin
            sentAny_r <= 1'b0;
        end else if (emit) begin
            sentAny_r <= 1'b1;
        end
    end

    // Count of start flags held; write side raises it, read side lowers it
    // detection indication
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            syncCount_r <= '0;
        end else if (flush_r) begin
            syncCount_r <= '0;
        end else begin
            syncCount_r <= syncCount_r + LEVEL_W'(push & wrSync)
                                       - LEVEL_W'(pop & headSync);
        end
    end

    // Registered parallel output to the line transmitter
    // valid qualifier
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txData_r  <= '0;
            txValid_r <= 1'b0;
            txSync_r  <= 1'b0;
        end else begin
            txValid_r <= emit;
            txSync_r  <= emit & headSync;
            if (emit) begin
                txData_r <= fifoRdData[DATA_W-1:0];
            end
        end
    end

    assign txData  = txData_r;
    assign txValid = txValid_r;
    assign txSync  = txSync_r;

    // Sent byte counter, cleared by flush
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            byteCount_r <= '0;
        end else if (flush_r) begin
            byteCount_r <= '0;
        end else if (emit) begin
            byteCount_r <= byteCount_r + 32'h0000_0001;
        end
    end

    // APB decode
    assign apbSetup  = psel & ~penable;
    assign apbAccess = psel & penable;
    assign apbWrite  = apbAccess & pwrite;
    assign selCtrl   = (paddr == OFS_CTRL);
    assign selStat   = (paddr == OFS_STAT);
    assign selBytes  = (paddr == OFS_BYTES);
    assign mapped    = selCtrl | selStat | selBytes;
    assign pready    = 1'b1;
    assign pslverr   = apbAccess & ~mapped;

    // Status word, reserved bits zero
    assign statWord = {11'h000, fifoFull, ~fifoRdValid, (state_r == RD_HOLD),
                       syncErr_r, ovf_r, 6'h00, fifoLevel};

    // Read mux
    assign readWord = selCtrl  ? ctrl_r :
                      selStat  ? statWord :
                      selBytes ? byteCount_r : 32'h0000_0000;

    // Read data captured in the setup phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (apbSetup && !pwrite) begin
            prdata_r <= readWord;
        end
    end

    assign prdata = prdata_r;

    // Control register; flush bit is a self-clearing pulse
    // control register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r  <= CTRL_RESET;
            flush_r <= 1'b0;
        end else begin
            flush_r <= apbWrite & selCtrl & pwdata[CTRL_FLUSH];
            if (apbWrite && selCtrl) begin
                ctrl_r <= {30'h0000_0000, pwdata[CTRL_USED_W-1:0]};
            end
        end
    end

    // Sticky errors, write one to clear, a new event wins over the clear
    assign ovfSet = srcValid & ~srcReady & enabled;
    assign errSet = push & srcStart & ~wrSync;
    assign ovfClr = apbWrite & selStat & pwdata[STAT_OVF];
    assign errClr = apbWrite & selStat & pwdata[STAT_SYNC_ERR];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovf_r     <= 1'b0;
            syncErr_r <= 1'b0;
        end else begin
            ovf_r     <= ovfSet | (ovf_r & ~ovfClr);
            syncErr_r <= errSet | (syncErr_r & ~errClr);
        end
    end
endmodule
`default_nettype wire

/* verilog/aopc_pkg.sv */
// Shared constants and types for the serial stream packet output controller
package aopc_pkg;

    // Stream word layout: 8 data bits plus the packet-start flag
    localparam int          DATA_W       = 8;
    localparam int          FIFO_W       = 9;
    localparam int          FIFO_DEPTH   = 512;
    localparam int          LEVEL_W      = 10;
    localparam int          SYNC_BIT     = 8;
    localparam logic [7:0]  SYNC_PATTERN = 8'h47;

    // APB register map, byte addresses
    localparam int          ADDR_W    = 12;
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_STAT  = 12'h004;
    localparam logic [11:0] OFS_BYTES = 12'h008;

    // Control register fields and reset value
    localparam int          CTRL_PKT_MODE = 0;
    localparam int          CTRL_ENABLE   = 1;
    localparam int          CTRL_FLUSH    = 2;
    localparam int          CTRL_USED_W   = 2;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Status register fields
    localparam int          STAT_LEVEL_LSB = 0;
    localparam int          STAT_OVF       = 16;
    localparam int          STAT_SYNC_ERR  = 17;
    localparam int          STAT_HOLD      = 18;
    localparam int          STAT_EMPTY     = 19;
    localparam int          STAT_FULL      = 20;

    // Release threshold: head packet start plus the next packet start
    localparam logic [9:0]  SYNC_RELEASE = 10'h002;

    // Read-side controller states
    typedef enum logic [2:0] {
        RD_SEEK = 3'b001,
        RD_HOLD = 3'b010,
        RD_SEND = 3'b100
    } aopc_rd_state_type;

endpackage

/* verilog/aopc_slot_sync.sv */
// Synchroniser and rising-edge detector for the transmitter byte slot clock
`timescale 1ns/1ps
`default_nettype none
module aopc_slot_sync (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Async reset, active high
    input  wire logic slotIn,    // Byte clock from line transmitter
    output logic      slotPulse  // One pulse per byte slot
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Two-stage synchroniser, then an edge history stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= slotIn;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Rising edge of the settled level
    assign slotPulse = sync_r & ~prev_r;
endmodule
`default_nettype wire
